// ==== pkg/pmcm_pkg.sv ====
// Constants, field layout and types of the power-managed clock mode control
package pmcm_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int STAB_TIME_MS  = 1;
	localparam int STAB_CYCLES   =
		(STAB_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_DLY_US   = 10;
	localparam int WAKE_CYCLES   =
		(WAKE_DLY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W         = 16;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int             ADDR_W       = 8;
	localparam logic [7:0]     OFS_OSC_CTRL = 8'h00;
	localparam logic [7:0]     OFS_TMR_CTRL = 8'h04;
	localparam logic [7:0]     OFS_MODE     = 8'h08;

	localparam int             OSC_IDLE_BIT = 7;
	localparam int             OSC_IFS_MSB  = 6;
	localparam int             OSC_IFS_LSB  = 4;
	localparam int             OSC_PRDY_BIT = 3;
	localparam int             OSC_ISTB_BIT = 2;
	localparam int             OSC_SCS_HI   = 1;
	localparam int             OSC_SCS_LO   = 0;
	localparam int             TMR_SACT_BIT = 6;
	localparam int             TMR_SEN_BIT  = 3;
	localparam int             MODE_MSB     = 6;

	localparam logic           IDLE_RST     = 1'b0;
	localparam logic [2:0]     IFS_RST      = 3'h0;
	localparam logic [1:0]     SCS_RST      = 2'h0;
	localparam logic           SEN_RST      = 1'b0;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		SRC_NONE = 2'h0,
		SRC_PRI  = 2'h1,
		SRC_SEC  = 2'h2,
		SRC_INT  = 2'h3
	} pmcm_src_t;

	typedef enum logic [6:0] {
		ST_PRIMARY_RUN_MODE = 7'h01,
		ST_ALT_RUN = 7'h02,
		ST_RETURN  = 7'h04,
		ST_IDLE    = 7'h08,
		ST_WAKE    = 7'h10,
		ST_SLEEP   = 7'h20,
		ST_SLWAKE  = 7'h40
	} pmcm_state_t;

endpackage

// ==== rtl/pmcm_delay.sv ====
// Run-level delay counter: done rises LIMIT cycles after run rises
`timescale 1ns/10ps
`default_nettype none

module pmcm_delay #(
	parameter int unsigned LIMIT = 1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      done
);

	localparam logic [pmcm_pkg::TMR_W-1:0] LIM_M1 =
		pmcm_pkg::TMR_W'(LIMIT - 1);

	logic [pmcm_pkg::TMR_W-1:0] cnt_q;
	logic [pmcm_pkg::TMR_W-1:0] cnt_d;
	logic                       done_q;
	logic                       done_d;

	always_comb begin
		cnt_d  = '0;
		done_d = 1'b0;
		if (run) begin
			done_d = done_q || (cnt_q == LIM_M1);
			cnt_d  = done_d ? cnt_q : cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;

endmodule

`default_nettype wire

// ==== rtl/pmcm_ctrl.sv ====
// Power-managed clock mode controller with APB register slave
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Idle with high select: CPU stops, peripherals on mux, primary off.
// - Nonzero frequency select: stable flag sets after about 1 ms.
// - Frequency select zero: mux disabled, stable flag clear, slow source used.
// - Stable flag stays set through a mode change that keeps the mux source, if already stable.
// - Idle wake: 10 us delay, CPU on mux until primary ready.
// - Power-down with idle clear and nonzero select: CPU and peripherals on selected source.
// - Watchdog timeout in a run mode requests a watchdog reset.
// - Alternate run exits on interrupt or reset; run modes also go to sleep, idle, reset.
// - Primary run by default; other modes return there on wake.
// - Primary run shows primary-ready flag set.
// - Select 01 run: secondary clock, primary off, secondary-active set.
// - Setting low select bit is ignored while secondary enable clear.
// - Secondary run wake: stay on secondary until primary ready.
// - Clearing secondary enable in secondary run returns to primary.
// - Run with high select: system on mux, primary off, flag cleared.
// - Frequency select writes change the mux frequency at once.
// - Internal run wake: stay on mux until primary ready, then switch.
// - Idle from alternate run: CPU halts, flags and peripheral source unchanged.
// - Sleep: primary and mux off, all flags clear.
// - Every reset clears the oscillator control register.
// - Watchdog timeout in idle or sleep wakes the device.
module pmcm_ctrl #(
	parameter int unsigned STAB_CYCLES = pmcm_pkg::STAB_CYCLES
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [pmcm_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          pwrdn_exec,
	input  wire logic                          wake_irq,
	input  wire logic                          wdt_timeout,
	input  wire logic                          reset_instr,
	input  wire logic                          primary_clk_ready,
	input  wire logic                          wdt_enable,
	input  wire logic                          fscm_enable,
	output logic                               cpu_clk_en,
	output logic                               periph_clk_en,
	output logic      [1:0]                    sys_clk_sel,
	output logic                               primary_osc_en,
	output logic                               secondary_osc_run,
	output logic                               internal_osc_mux_en,
	output logic      [2:0]                    internal_freq,
	output logic                               lf_osc_en,
	output logic                               wdt_reset_req,
	output logic                               soft_reset_req
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic pmcm_pkg::pmcm_src_t scs_src(input logic [1:0] s);
		if (s[1])
			return pmcm_pkg::SRC_INT;
		else if (s[0])
			return pmcm_pkg::SRC_SEC;
		else
			return pmcm_pkg::SRC_PRI;
	endfunction

	// ************************************************************
	// Declarations
	// ************************************************************
	pmcm_pkg::pmcm_state_t st_q;
	pmcm_pkg::pmcm_state_t st_d;
	pmcm_pkg::pmcm_src_t   src_q;
	pmcm_pkg::pmcm_src_t   src_d;
	pmcm_pkg::pmcm_src_t   tgt;
	pmcm_pkg::pmcm_src_t   mode_src_q;
	pmcm_pkg::pmcm_src_t   mode_src_d;
	logic                  idle_q;
	logic                  idle_d;
	logic [2:0]            ifs_q;
	logic [2:0]            ifs_d;
	logic [1:0]            scs_q;
	logic [1:0]            scs_d;
	logic                  sen_q;
	logic                  sen_d;
	logic [31:0]           prdata_q;
	logic [31:0]           prdata_d;
	logic                  pready_q;
	logic                  pready_d;
	logic                  pslverr_q;
	logic                  pslverr_d;
	logic                  cpu_en_q;
	logic                  cpu_en_d;
	logic                  per_en_q;
	logic                  per_en_d;
	logic                  pri_en_q;
	logic                  pri_en_d;
	logic                  mux_en_q;
	logic                  mux_en_d;
	logic                  lf_en_q;
	logic                  lf_en_d;
	logic                  secondary_osc_run_mode_q;
	logic                  secondary_osc_run_mode_d;
	logic                  prdy_q;
	logic                  prdy_d;
	logic                  sact_q;
	logic                  sact_d;
	logic                  wdt_rst_q;
	logic                  wdt_rst_d;
	logic                  soft_rst_q;
	logic                  soft_rst_d;
	logic                  clr_regs;
	logic                  stab_done;
	logic                  wake_done;
	logic                  istb;
	logic                  wr_done;
	logic                  acc;
	logic [31:0]           rd_val;
	logic                  hit;

	// ************************************************************
	// Delay counters
	// ************************************************************
	pmcm_delay #(
		.LIMIT (STAB_CYCLES)
	) u_stab (
		.clk   (pclk),
		.rst_n (presetn),
		.run   (mux_en_q),
		.done  (stab_done)
	);

	pmcm_delay #(
		.LIMIT (pmcm_pkg::WAKE_CYCLES)
	) u_wake (
		.clk   (pclk),
		.rst_n (presetn),
		.run   (st_q == pmcm_pkg::ST_WAKE),
		.done  (wake_done)
	);

	assign istb = stab_done && mux_en_q;

	// ************************************************************
	// APB register slave
	// ************************************************************
	assign wr_done = psel && penable && pready_q && pwrite;
	assign acc     = psel && penable && !pready_q;

	always_comb begin
		idle_d    = idle_q;
		ifs_d     = ifs_q;
		scs_d     = scs_q;
		sen_d     = sen_q;
		rd_val    = 32'h0000_0000;
		hit       = 1'b1;
		pready_d  = acc;
		prdata_d  = 32'h0000_0000;
		pslverr_d = 1'b0;
		unique case (paddr)
			pmcm_pkg::OFS_OSC_CTRL: begin
				rd_val[pmcm_pkg::OSC_IDLE_BIT] = idle_q;
				rd_val[pmcm_pkg::OSC_IFS_MSB:pmcm_pkg::OSC_IFS_LSB] = ifs_q;
				rd_val[pmcm_pkg::OSC_PRDY_BIT] = prdy_q;
				rd_val[pmcm_pkg::OSC_ISTB_BIT] = istb;
				rd_val[pmcm_pkg::OSC_SCS_HI:pmcm_pkg::OSC_SCS_LO] = scs_q;
			end
			pmcm_pkg::OFS_TMR_CTRL: begin
				rd_val[pmcm_pkg::TMR_SACT_BIT] = sact_q;
				rd_val[pmcm_pkg::TMR_SEN_BIT]  = sen_q;
			end
			pmcm_pkg::OFS_MODE: begin
				rd_val[pmcm_pkg::MODE_MSB:0] = st_q;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		if (acc) begin
			prdata_d  = pwrite ? 32'h0000_0000 : rd_val;
			pslverr_d = !hit;
		end
		if (wr_done && paddr == pmcm_pkg::OFS_OSC_CTRL) begin
			idle_d   = pwdata[pmcm_pkg::OSC_IDLE_BIT];
			ifs_d    = pwdata[pmcm_pkg::OSC_IFS_MSB:pmcm_pkg::OSC_IFS_LSB];
			scs_d[1] = pwdata[pmcm_pkg::OSC_SCS_HI];
			if (!(pwdata[pmcm_pkg::OSC_SCS_LO] && !sen_q)) begin
				scs_d[0] = pwdata[pmcm_pkg::OSC_SCS_LO];
			end
		end
		if (wr_done && paddr == pmcm_pkg::OFS_TMR_CTRL) begin
			sen_d = pwdata[pmcm_pkg::TMR_SEN_BIT];
		end
		if (clr_regs) begin
			idle_d = pmcm_pkg::IDLE_RST;
			ifs_d  = pmcm_pkg::IFS_RST;
			scs_d  = pmcm_pkg::SCS_RST;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_q    <= pmcm_pkg::IDLE_RST;
			ifs_q     <= pmcm_pkg::IFS_RST;
			scs_q     <= pmcm_pkg::SCS_RST;
			sen_q     <= pmcm_pkg::SEN_RST;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			idle_q    <= idle_d;
			ifs_q     <= ifs_d;
			scs_q     <= scs_d;
			sen_q     <= sen_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ************************************************************
	// Mode sequencer and clock source switch
	// ************************************************************
	always_comb begin
		st_d       = st_q;
		mode_src_d = mode_src_q;
		wdt_rst_d  = 1'b0;
		soft_rst_d = 1'b0;
		clr_regs   = 1'b0;
		unique case (st_q)
			pmcm_pkg::ST_PRIMARY_RUN_MODE, pmcm_pkg::ST_ALT_RUN,
			pmcm_pkg::ST_RETURN: begin
				if (wdt_timeout || reset_instr) begin
					wdt_rst_d  = wdt_timeout;
					soft_rst_d = !wdt_timeout && reset_instr;
					clr_regs   = 1'b1;
					st_d       = pmcm_pkg::ST_SLWAKE;
					mode_src_d = pmcm_pkg::SRC_PRI;
				end else if (pwrdn_exec) begin
					if (!idle_q && scs_q == 2'h0) begin
						st_d = pmcm_pkg::ST_SLEEP;
					end else if (idle_q) begin
						st_d = pmcm_pkg::ST_IDLE;
						if (st_q == pmcm_pkg::ST_PRIMARY_RUN_MODE) begin
							mode_src_d = scs_src(scs_q);
						end
					end else begin
						st_d       = pmcm_pkg::ST_ALT_RUN;
						mode_src_d = scs_src(scs_q);
					end
				end else if (st_q == pmcm_pkg::ST_ALT_RUN &&
					(wake_irq || (mode_src_q == pmcm_pkg::SRC_SEC &&
					!sen_q))) begin
					st_d = pmcm_pkg::ST_RETURN;
				end else if (st_q == pmcm_pkg::ST_RETURN &&
					src_q == pmcm_pkg::SRC_PRI) begin
					st_d = pmcm_pkg::ST_PRIMARY_RUN_MODE;
				end
			end
			pmcm_pkg::ST_IDLE: begin
				if (wake_irq || wdt_timeout) begin
					st_d = pmcm_pkg::ST_WAKE;
				end
			end
			pmcm_pkg::ST_WAKE: begin
				if (wake_done) begin
					st_d = (mode_src_q == pmcm_pkg::SRC_PRI) ?
						pmcm_pkg::ST_PRIMARY_RUN_MODE : pmcm_pkg::ST_RETURN;
				end
			end
			pmcm_pkg::ST_SLEEP: begin
				if (wake_irq || wdt_timeout) begin
					st_d = pmcm_pkg::ST_SLWAKE;
				end
			end
			pmcm_pkg::ST_SLWAKE: begin
				if (src_q == pmcm_pkg::SRC_PRI) begin
					st_d = pmcm_pkg::ST_PRIMARY_RUN_MODE;
				end
			end
		endcase

		unique case (st_q)
			pmcm_pkg::ST_PRIMARY_RUN_MODE: tgt = pmcm_pkg::SRC_PRI;
			pmcm_pkg::ST_SLEEP:   tgt = pmcm_pkg::SRC_NONE;
			pmcm_pkg::ST_SLWAKE:
				tgt = primary_clk_ready ? pmcm_pkg::SRC_PRI : pmcm_pkg::SRC_NONE;
			pmcm_pkg::ST_RETURN:
				tgt = primary_clk_ready ? pmcm_pkg::SRC_PRI : mode_src_q;
			default:              tgt = mode_src_q;
		endcase
		if (tgt != src_q && src_q != pmcm_pkg::SRC_NONE)
			src_d = pmcm_pkg::SRC_NONE;
		else
			src_d = tgt;

		cpu_en_d  = (st_d == pmcm_pkg::ST_PRIMARY_RUN_MODE ||
			st_d == pmcm_pkg::ST_ALT_RUN || st_d == pmcm_pkg::ST_RETURN) &&
			src_d != pmcm_pkg::SRC_NONE;
		per_en_d  = st_d != pmcm_pkg::ST_SLEEP &&
			src_d != pmcm_pkg::SRC_NONE;
		pri_en_d  = !(st_d == pmcm_pkg::ST_SLEEP ||
			st_d == pmcm_pkg::ST_ALT_RUN ||
			(st_d == pmcm_pkg::ST_IDLE &&
			mode_src_d != pmcm_pkg::SRC_PRI));
		mux_en_d  = src_d == pmcm_pkg::SRC_INT && ifs_d != 3'h0;
		lf_en_d   = wdt_enable || (fscm_enable &&
			st_d != pmcm_pkg::ST_SLEEP) ||
			(src_d == pmcm_pkg::SRC_INT && ifs_d == 3'h0);
		secondary_osc_run_mode_d = sen_d || src_d == pmcm_pkg::SRC_SEC;
		prdy_d    = src_d == pmcm_pkg::SRC_PRI;
		sact_d    = src_d == pmcm_pkg::SRC_SEC;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q       <= pmcm_pkg::ST_SLWAKE;
			mode_src_q <= pmcm_pkg::SRC_PRI;
			src_q      <= pmcm_pkg::SRC_NONE;
			cpu_en_q   <= 1'b0;
			per_en_q   <= 1'b0;
			pri_en_q   <= 1'b1;
			mux_en_q   <= 1'b0;
			lf_en_q    <= 1'b0;
			secondary_osc_run_mode_q  <= 1'b0;
			prdy_q     <= 1'b0;
			sact_q     <= 1'b0;
			wdt_rst_q  <= 1'b0;
			soft_rst_q <= 1'b0;
		end else begin
			st_q       <= st_d;
			mode_src_q <= mode_src_d;
			src_q      <= src_d;
			cpu_en_q   <= cpu_en_d;
			per_en_q   <= per_en_d;
			pri_en_q   <= pri_en_d;
			mux_en_q   <= mux_en_d;
			lf_en_q    <= lf_en_d;
			secondary_osc_run_mode_q  <= secondary_osc_run_mode_d;
			prdy_q     <= prdy_d;
			sact_q     <= sact_d;
			wdt_rst_q  <= wdt_rst_d;
			soft_rst_q <= soft_rst_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata              = prdata_q;
	assign pready              = pready_q;
	assign pslverr             = pslverr_q;
	assign cpu_clk_en          = cpu_en_q;
	assign periph_clk_en       = per_en_q;
	assign sys_clk_sel         = src_q;
	assign primary_osc_en      = pri_en_q;
	assign secondary_osc_run   = secondary_osc_run_mode_q;
	assign internal_osc_mux_en = mux_en_q;
	assign internal_freq       = ifs_q;
	assign lf_osc_en           = lf_en_q;
	assign wdt_reset_req       = wdt_rst_q;
	assign soft_reset_req      = soft_rst_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ifs_zero_flag: assert property ((ifs_q == 3'h0) |-> !istb)
		else $error("stable flag set with frequency select zero");
	a_scs_low_ignore: assert property ((wr_done &&
		paddr == pmcm_pkg::OFS_OSC_CTRL && pwdata[0] && !sen_q &&
		!clr_regs) |=> (scs_q[0] == $past(scs_q[0])))
		else $error("low select bit written while secondary disabled");
	a_internal_osc_idle_mode_entry: assert property ((st_q == pmcm_pkg::ST_PRIMARY_RUN_MODE &&
		pwrdn_exec && idle_q && scs_q[1] && !wdt_timeout &&
		!reset_instr) |-> ##[1:3] (!cpu_clk_en && !primary_osc_en &&
		sys_clk_sel == pmcm_pkg::SRC_INT && !prdy_q))
		else $error("internal idle entry did not switch clocks");
	a_break_make: assert property ((sys_clk_sel != pmcm_pkg::SRC_NONE)
		##1 (sys_clk_sel != $past(sys_clk_sel)) |->
		(sys_clk_sel == pmcm_pkg::SRC_NONE))
		else $error("clock source changed without dead cycle");
	a_wdt_reset: assert property (((st_q == pmcm_pkg::ST_PRIMARY_RUN_MODE ||
		st_q == pmcm_pkg::ST_ALT_RUN ||
		st_q == pmcm_pkg::ST_RETURN) && wdt_timeout) |=>
		(wdt_reset_req && !idle_q && scs_q == 2'h0))
		else $error("watchdog in run mode gave no reset");
	a_wdt_wake: assert property ((st_q == pmcm_pkg::ST_IDLE &&
		wdt_timeout) |=> (st_q == pmcm_pkg::ST_WAKE && !wdt_reset_req))
		else $error("watchdog in idle did not wake");
	a_wake_hold: assert property ($rose(st_q == pmcm_pkg::ST_WAKE) |->
		(st_q == pmcm_pkg::ST_WAKE && !cpu_clk_en)[*8])
		else $error("CPU started before wake delay");
	a_sleep_flags: assert property ((st_q == pmcm_pkg::ST_SLEEP) ##1
		(st_q == pmcm_pkg::ST_SLEEP) |-> (!prdy_q && !istb && !sact_q &&
		!primary_osc_en && !internal_osc_mux_en))
		else $error("sleep left a clock or flag active");
	a_pri_flag: assert property ((st_q == pmcm_pkg::ST_PRIMARY_RUN_MODE)[*3] |->
		prdy_q)
		else $error("primary run without primary ready flag");
	a_sec_flag: assert property ((st_q == pmcm_pkg::ST_ALT_RUN &&
		sys_clk_sel == pmcm_pkg::SRC_SEC) |-> (sact_q && !prdy_q &&
		secondary_osc_run))
		else $error("secondary run flags wrong");

	c_alt_run: cover property (st_q == pmcm_pkg::ST_ALT_RUN &&
		sys_clk_sel == pmcm_pkg::SRC_INT);
	c_return: cover property ((st_q == pmcm_pkg::ST_RETURN) ##1
		(st_q == pmcm_pkg::ST_PRIMARY_RUN_MODE));
	c_sleep_wake: cover property ((st_q == pmcm_pkg::ST_SLEEP) ##1
		(st_q == pmcm_pkg::ST_SLWAKE));
	c_stable: cover property ($rose(istb));

endmodule

`default_nettype wire

// ==== bench/pmcm_osc_model.sv ====
// Primary oscillator model: ready after a start-up count
`timescale 1ns/10ps
`default_nettype none

module pmcm_osc_model #(
	parameter int unsigned START = 20
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic primary_osc_en,
	output logic      primary_clk_ready
);
	int unsigned cnt_q;

	// Ready drops at once when the oscillator is shut down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			primary_clk_ready <= 1'b0;
		end else if (!primary_osc_en) begin
			cnt_q <= 0;
			primary_clk_ready <= 1'b0;
		end else if (cnt_q == START) begin
			primary_clk_ready <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench of the clock mode controller
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module testbench;
	localparam logic [7:0] A_OSC = pmcm_pkg::OFS_OSC_CTRL;
	localparam logic [7:0] A_TMR = pmcm_pkg::OFS_TMR_CTRL;
	localparam logic [7:0] A_MOD = pmcm_pkg::OFS_MODE;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pwrdn_exec = 1'b0;
	logic        wake_irq = 1'b0;
	logic        wdt_timeout = 1'b0;
	logic        reset_instr = 1'b0;
	logic        primary_clk_ready;
	logic        wdt_enable = 1'b1;
	logic        fscm_enable = 1'b0;
	logic        cpu_clk_en;
	logic        periph_clk_en;
	logic [1:0]  sys_clk_sel;
	logic        primary_osc_en;
	logic        secondary_osc_run;
	logic        internal_osc_mux_en;
	logic [2:0]  internal_freq;
	logic        lf_osc_en;
	logic        wdt_reset_req;
	logic        soft_reset_req;
	logic [31:0] rd;
	logic        er;
	logic        seen;
	int          num_errors = 0;
	int          cmp_count = 0;

	always #12.5 pclk = ~pclk;

	pmcm_ctrl #(.STAB_CYCLES(20)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pwrdn_exec(pwrdn_exec),
		.wake_irq(wake_irq), .wdt_timeout(wdt_timeout),
		.reset_instr(reset_instr), .primary_clk_ready(primary_clk_ready),
		.wdt_enable(wdt_enable), .fscm_enable(fscm_enable),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.sys_clk_sel(sys_clk_sel), .primary_osc_en(primary_osc_en),
		.secondary_osc_run(secondary_osc_run),
		.internal_osc_mux_en(internal_osc_mux_en),
		.internal_freq(internal_freq), .lf_osc_en(lf_osc_en),
		.wdt_reset_req(wdt_reset_req), .soft_reset_req(soft_reset_req)
	);

	pmcm_osc_model u_osc (
		.pclk(pclk), .presetn(presetn), .primary_osc_en(primary_osc_en),
		.primary_clk_ready(primary_clk_ready)
	);

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Pulse 0 power-down, 1 interrupt, 2 watchdog, 3 reset instr
	task automatic pulse(input int k);
		@(posedge pclk);
		case (k)
			0: pwrdn_exec <= 1'b1;
			1: wake_irq <= 1'b1;
			2: wdt_timeout <= 1'b1;
			default: reset_instr <= 1'b1;
		endcase
		@(posedge pclk);
		{pwrdn_exec, wake_irq, wdt_timeout, reset_instr} <= 4'h0;
	endtask

	task automatic wmode(input logic [6:0] m);
		int i;
		rd = 32'h0;
		for (i = 0; i < 3000 && rd[6:0] !== m; i++) apb(1'b0, A_MOD, 32'h0);
		`CHK(rd[6:0], m)
	endtask

	task automatic req_seen(input int k);
		seen = 1'b0;
		fork
			pulse(k);
			repeat (4) @(posedge pclk) seen |= (k == 2) ? wdt_reset_req
				: soft_reset_req;
		join
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset;
		wmode(7'h01);
		apb(1'b0, A_OSC, 32'h0);
		`CHK(rd[7:0], 8'h08)
		`CHK(sys_clk_sel, 2'h1)
		apb(1'b0, 8'h40, 32'h0);
		`CHK({er, rd}, 33'h100000000)
		$display("end test reset");
	endtask

	task automatic t_secondary;
		apb(1'b1, A_OSC, 32'h1);
		apb(1'b0, A_OSC, 32'h0);
		`CHK(rd[0], 1'b0)
		apb(1'b1, A_TMR, 32'h8);
		apb(1'b1, A_OSC, 32'h1);
		pulse(0);
		wmode(7'h02);
		`CHK({sys_clk_sel, primary_osc_en, cpu_clk_en}, 4'h9)
		apb(1'b0, A_TMR, 32'h0);
		`CHK(rd[6], 1'b1)
		apb(1'b1, A_TMR, 32'h0);
		repeat (3) @(posedge pclk);
		`CHK({sys_clk_sel, primary_osc_en}, 3'h5)
		wmode(7'h01);
		`CHK({sys_clk_sel, secondary_osc_run}, 3'h2)
		apb(1'b0, A_TMR, 32'h0);
		`CHK(rd[6], 1'b0)
		apb(1'b0, A_OSC, 32'h0);
		`CHK(rd[3], 1'b1)
		$display("end test secondary");
	endtask

	task automatic t_internal;
		apb(1'b1, A_OSC, 32'h32);
		pulse(0);
		wmode(7'h02);
		`CHK({sys_clk_sel, primary_osc_en, internal_osc_mux_en}, 4'hD)
		apb(1'b0, A_OSC, 32'h0);
		`CHK(rd[3:2], 2'h0)
		repeat (40) @(posedge pclk);
		apb(1'b0, A_OSC, 32'h0);
		`CHK(rd[3:2], 2'h1)
		apb(1'b1, A_OSC, 32'h52);
		@(posedge pclk);
		`CHK(internal_freq, 3'h5)
		apb(1'b1, A_OSC, 32'hD2);
		pulse(0);
		repeat (3) @(posedge pclk);
		`CHK({cpu_clk_en, periph_clk_en, sys_clk_sel}, 4'h7)
		apb(1'b0, A_OSC, 32'h0);
		`CHK(rd[3:2], 2'h1)
		req_seen(2);
		`CHK(seen, 1'b0)
		repeat (100) @(posedge pclk);
		`CHK({cpu_clk_en, periph_clk_en, sys_clk_sel}, 4'h7)
		wmode(7'h01);
		apb(1'b0, A_OSC, 32'h0);
		`CHK(rd[7:0], 8'hDA)
		pulse(0);
		repeat (3) @(posedge pclk);
		`CHK({cpu_clk_en, sys_clk_sel, primary_osc_en}, 4'h6)
		pulse(1);
		wmode(7'h01);
		apb(1'b0, A_OSC, 32'h0);
		`CHK(rd[7:0], 8'hDA)
		apb(1'b1, A_OSC, 32'h52);
		pulse(0);
		wmode(7'h02);
		pulse(1);
		@(posedge pclk);
		`CHK({sys_clk_sel, primary_osc_en}, 3'h7)
		wmode(7'h01);
		apb(1'b0, A_OSC, 32'h0);
		`CHK(rd[7:0], 8'h5A)
		$display("end test internal");
	endtask

	task automatic t_sleep;
		apb(1'b1, A_OSC, 32'h0);
		pulse(0);
		wmode(7'h20);
		`CHK({primary_osc_en, internal_osc_mux_en, lf_osc_en}, 3'h1)
		`CHK({cpu_clk_en, periph_clk_en}, 2'h0)
		apb(1'b0, A_OSC, 32'h0);
		`CHK(rd[3:2], 2'h0)
		wdt_enable <= 1'b0;
		fscm_enable <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK(lf_osc_en, 1'b0)
		req_seen(2);
		`CHK(seen, 1'b0)
		wmode(7'h01);
		`CHK(lf_osc_en, 1'b1)
		wdt_enable <= 1'b1;
		$display("end test sleep");
	endtask

	task automatic t_resets;
		apb(1'b1, A_OSC, 32'h32);
		req_seen(2);
		`CHK(seen, 1'b1)
		wmode(7'h01);
		apb(1'b0, A_OSC, 32'h0);
		`CHK(rd[7:0], 8'h08)
		req_seen(3);
		`CHK(seen, 1'b1)
		wmode(7'h01);
		$display("end test resets");
	endtask

	task automatic print_verdict;
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_secondary();
		t_internal();
		t_sleep();
		t_resets();
		print_verdict();
	end

	initial begin
		#1000000;
		num_errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
